// >>> pkg/fes_pkg.sv
package fes_pkg;

	// ==============================
	// Command codes written to the flash
	localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
	localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
	localparam logic [7:0] CMD_BLOCK_SETUP  = 8'h20;
	localparam logic [7:0] CMD_CHIP_SETUP   = 8'h30;
	localparam logic [7:0] CMD_CONFIRM      = 8'hD0;
	localparam logic [7:0] CMD_READ_ARRAY   = 8'hFF;

	// ==============================
	// Operation status bit positions
	localparam int ST_READY_BIT    = 7;
	localparam int ST_ESUSP_BIT    = 6;
	localparam int ST_EFAIL_BIT    = 5;
	localparam int ST_PFAIL_BIT    = 4;
	localparam int ST_SUPPLY_BIT   = 3;
	localparam int ST_PSUSP_BIT    = 2;
	localparam int ST_PROTECT_BIT  = 1;
	localparam logic [7:0] ST_POLL_MASK = 8'hFE;

	// ==============================
	// Bus timing, in ns and in 100 ns cycles
	localparam int CLK_PERIOD_NS  = 100;
	localparam int BUS_PULSE_NS   = 100;
	localparam int BUS_PULSE_CYC  = (BUS_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ==============================
	// Result codes reported to the user
	typedef enum logic [2:0] {
		RES_OK      = 3'b000,
		RES_SUPPLY  = 3'b001,
		RES_PROTECT = 3'b010,
		RES_SEQ     = 3'b011,
		RES_ERASE   = 3'b100
	} fes_result_t;

	// ==============================
	// Bus cycle kinds
	typedef enum logic [1:0] {
		BC_WRITE = 2'b01,
		BC_READ  = 2'b10
	} fes_cycle_t;

endpackage

// >>> design/fes_bus_cycle.sv
`timescale 1ns/1ps
// ==============================
// One write or read cycle on the flash pins
module fes_bus_cycle
	import fes_pkg::*;
#(
	parameter int PULSE_CYC = BUS_PULSE_CYC,
	parameter int AW        = 20
) (
	input  wire logic             ref_clk_i,
	input  wire logic             srst_i,
	input  wire logic             start_i,
	input  wire fes_cycle_t       kind_i,
	input  wire logic [AW-1:0]    addr_i,
	input  wire logic [7:0]       wdata_i,
	output logic                  done_o,
	output logic [7:0]            rdata_o,
	output logic [AW-1:0]         addr_o,
	output logic                  ce_n_o,
	output logic                  we_n_o,
	output logic                  oe_n_o,
	output logic [7:0]            dq_o,
	output logic                  dq_oe_o,
	input  wire logic [7:0]       dq_i
);
	initial begin
		if (PULSE_CYC < 1 || PULSE_CYC > 255) begin
			$error("PULSE_CYC out of range");
		end
	end

	logic [7:0] cnt_ff;
	logic       act_ff;
	logic       rd_ff;

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			act_ff  <= 1'b0;
			rd_ff   <= 1'b0;
			cnt_ff  <= 8'h00;
			addr_o  <= '0;
			dq_o    <= 8'h00;
			dq_oe_o <= 1'b0;
			ce_n_o  <= 1'b1;
			we_n_o  <= 1'b1;
			oe_n_o  <= 1'b1;
			rdata_o <= 8'h00;
			done_o  <= 1'b0;
		end else begin
			done_o <= 1'b0;
			if (!act_ff && start_i) begin
				act_ff  <= 1'b1;
				rd_ff   <= (kind_i == BC_READ);
				cnt_ff  <= 8'(PULSE_CYC);
				addr_o  <= addr_i;
				dq_o    <= wdata_i;
				dq_oe_o <= (kind_i == BC_WRITE);
				ce_n_o  <= 1'b0;
				we_n_o  <= (kind_i != BC_WRITE);
				oe_n_o  <= (kind_i != BC_READ);
			end else if (act_ff) begin
				if (cnt_ff == 8'h00) begin
					// Data latched on the rising strobe edge
					act_ff  <= 1'b0;
					ce_n_o  <= 1'b1;
					we_n_o  <= 1'b1;
					oe_n_o  <= 1'b1;
					dq_oe_o <= 1'b0;
					done_o  <= 1'b1;
					if (rd_ff) begin
						rdata_o <= dq_i;
					end
				end else begin
					cnt_ff <= cnt_ff - 8'h01;
				end
			end
		end
	end
endmodule

// >>> design/fes_erase_host.sv
`timescale 1ns/1ps
// What this block does
// - Write 70H, read status, wait for bit 7 set meaning ready.
// - Host masks reserved bit 0 out of every status comparison.
// - Block erase: 20H anywhere, then D0H inside the target block.
// - Chip erase: 30H then D0H at any address; check afterwards.
// - Block erases may run back to back; check per erase or once.
// - After the final erase write FFH to return to array read.
// - Check supply, then protect, then sequence, then erase error.
// - On any error clear status before anything else.
module fes_erase_host
	import fes_pkg::*;
#(
	parameter int AW = 20
) (
	input  wire logic             ref_clk_i,
	input  wire logic             srst_i,
	input  wire logic             op_start_i,
	input  wire logic             op_chip_i,
	input  wire logic [AW-1:0]    op_addr_i,
	input  wire logic             op_check_i,
	input  wire logic             op_last_i,
	output logic                  op_ready_o,
	output logic                  op_done_o,
	output fes_result_t           op_result_o,
	output logic [7:0]            op_status_o,
	output logic                  op_suspended_o,
	input  wire logic             ready_busy_i,
	output logic [AW-1:0]         flash_addr_o,
	output logic                  flash_ce_n_o,
	output logic                  flash_we_n_o,
	output logic                  flash_oe_n_o,
	output logic [7:0]            flash_dq_o,
	output logic                  flash_dq_oe_o,
	input  wire logic [7:0]       flash_dq_i
);
	initial begin
		if (AW < 1 || AW > 32) begin
			$error("AW out of range");
		end
	end

	// ==============================
	// State machine
	typedef enum logic [3:0] {
		S_IDLE    = 4'b0000,
		S_RSTAT   = 4'b0001,
		S_RPOLL0  = 4'b0010,
		S_SETUP   = 4'b0011,
		S_CONFIRM = 4'b0100,
		S_POLL    = 4'b0101,
		S_CHECK   = 4'b0110,
		S_CLEAR   = 4'b0111,
		S_ARRAY   = 4'b1000,
		S_FINISH  = 4'b1001
	} fes_state_t;

	fes_state_t      state_ff;
	fes_state_t      nxt_state;
	logic            chip_ff;
	logic            check_ff;
	logic            last_ff;
	logic [AW-1:0]   addr_ff;
	fes_result_t     result_ff;
	logic            issued_ff;

	logic            bc_start;
	fes_cycle_t      bc_kind;
	logic [AW-1:0]   bc_addr;
	logic [7:0]      bc_wdata;
	logic            bc_done;
	logic [7:0]      bc_rdata;

	// Reserved bit 0 never takes part in a comparison
	function automatic logic [7:0] masked(input logic [7:0] s);
		masked = s & ST_POLL_MASK;
	endfunction

	// Fixed order of the full status check
	function automatic fes_result_t classify(input logic [7:0] s);
		logic [7:0] m;
		m = masked(s);
		if (m[ST_SUPPLY_BIT]) begin
			classify = RES_SUPPLY;
		end else if (m[ST_PROTECT_BIT]) begin
			classify = RES_PROTECT;
		end else if (m[ST_PFAIL_BIT] && m[ST_EFAIL_BIT]) begin
			classify = RES_SEQ;
		end else if (m[ST_EFAIL_BIT]) begin
			classify = RES_ERASE;
		end else begin
			classify = RES_OK;
		end
	endfunction

	// ==============================
	// Pin cycle engine
	fes_bus_cycle #(
		.PULSE_CYC (BUS_PULSE_CYC),
		.AW        (AW)
	) u_cycle (
		.ref_clk_i (ref_clk_i),
		.srst_i    (srst_i),
		.start_i   (bc_start),
		.kind_i    (bc_kind),
		.addr_i    (bc_addr),
		.wdata_i   (bc_wdata),
		.done_o    (bc_done),
		.rdata_o   (bc_rdata),
		.addr_o    (flash_addr_o),
		.ce_n_o    (flash_ce_n_o),
		.we_n_o    (flash_we_n_o),
		.oe_n_o    (flash_oe_n_o),
		.dq_o      (flash_dq_o),
		.dq_oe_o   (flash_dq_oe_o),
		.dq_i      (flash_dq_i)
	);

	// ==============================
	// Cycle requests per state
	always_comb begin
		bc_kind  = BC_WRITE;
		bc_addr  = '0;
		bc_wdata = 8'h00;
		case (state_ff)
			S_RSTAT: begin
				bc_wdata = CMD_READ_STATUS;
			end
			S_RPOLL0, S_POLL: begin
				bc_kind = BC_READ;
			end
			S_SETUP: begin
				bc_wdata = chip_ff ? CMD_CHIP_SETUP : CMD_BLOCK_SETUP;
			end
			S_CONFIRM: begin
				bc_wdata = CMD_CONFIRM;
				bc_addr  = chip_ff ? '0 : addr_ff;
			end
			S_CLEAR: begin
				bc_wdata = CMD_CLEAR_STATUS;
			end
			S_ARRAY: begin
				bc_wdata = CMD_READ_ARRAY;
			end
			default: begin
				bc_wdata = 8'h00;
			end
		endcase
	end

	assign bc_start = !issued_ff && (state_ff != S_IDLE) && (state_ff != S_CHECK)
		&& (state_ff != S_FINISH);

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			issued_ff <= 1'b0;
		end else if (bc_done) begin
			issued_ff <= 1'b0;
		end else if (bc_start) begin
			issued_ff <= 1'b1;
		end
	end

	// ==============================
	// Sequencing
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			S_IDLE: begin
				if (op_start_i) begin
					nxt_state = S_RSTAT;
				end
			end
			S_RSTAT: begin
				if (bc_done) begin
					nxt_state = S_RPOLL0;
				end
			end
			S_RPOLL0: begin
				if (bc_done && bc_rdata[ST_READY_BIT]) begin
					nxt_state = S_SETUP;
				end
			end
			S_SETUP: begin
				if (bc_done) begin
					nxt_state = S_CONFIRM;
				end
			end
			S_CONFIRM: begin
				if (bc_done) begin
					nxt_state = S_POLL;
				end
			end
			S_POLL: begin
				// ready pin and bit 7 agree
				if (bc_done && bc_rdata[ST_READY_BIT] && ready_busy_i) begin
					nxt_state = S_CHECK;
				end
			end
			S_CHECK: begin
				if (check_ff && classify(op_status_o) != RES_OK) begin
					nxt_state = S_CLEAR;
				end else if (last_ff) begin
					nxt_state = S_ARRAY;
				end else begin
					nxt_state = S_FINISH;
				end
			end
			S_CLEAR: begin
				if (bc_done) begin
					nxt_state = last_ff ? S_ARRAY : S_FINISH;
				end
			end
			S_ARRAY: begin
				if (bc_done) begin
					nxt_state = S_FINISH;
				end
			end
			S_FINISH: begin
				nxt_state = S_IDLE;
			end
			default: begin
				nxt_state = S_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			state_ff <= S_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			chip_ff  <= 1'b0;
			check_ff <= 1'b0;
			last_ff  <= 1'b0;
			addr_ff  <= '0;
		end else if (state_ff == S_IDLE && op_start_i) begin
			chip_ff  <= op_chip_i;
			// Chip erase always gets its check
			check_ff <= op_check_i || op_chip_i;
			last_ff  <= op_last_i;
			addr_ff  <= op_addr_i;
		end
	end

	// ==============================
	// Status and results
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			op_status_o    <= 8'h00;
			op_suspended_o <= 1'b0;
		end else if (state_ff == S_POLL && bc_done) begin
			// sticky bits are reported as read
			op_status_o    <= masked(bc_rdata);
			op_suspended_o <= bc_rdata[ST_ESUSP_BIT] | bc_rdata[ST_PSUSP_BIT];
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			result_ff <= RES_OK;
		end else if (state_ff == S_CHECK) begin
			result_ff <= check_ff ? classify(op_status_o) : RES_OK;
		end
	end

	assign op_result_o = result_ff;
	assign op_done_o   = (state_ff == S_FINISH);
	assign op_ready_o  = (state_ff == S_IDLE);
endmodule

// >>> testbench/fes_erase_host_assertions.sv
`timescale 1ns/1ps
module fes_erase_host_checker (
	input wire logic       ref_clk_i,
	input wire logic       srst_i,
	input wire logic       op_start_i,
	input wire logic       op_ready_o,
	input wire logic       op_done_o,
	input wire logic [7:0] op_status_o,
	input wire logic       ready_busy_i,
	input wire logic       flash_ce_n_o,
	input wire logic       flash_we_n_o,
	input wire logic       flash_oe_n_o,
	input wire logic       flash_dq_oe_o
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (srst_i);
	// ==============================
	// Pin cycle and handshake checks
	read_no_drive_a: assert property (!flash_oe_n_o |-> !flash_dq_oe_o && !flash_ce_n_o)
		else $error("host drives data during a read");
	write_select_a: assert property (!flash_we_n_o |-> !flash_ce_n_o && flash_dq_oe_o)
		else $error("write strobe without select or data");
	write_len_a: assert property ($fell(flash_we_n_o) |=> !flash_we_n_o ##1 flash_we_n_o)
		else $error("write strobe length wrong");
	done_pulse_a: assert property (op_done_o |=> !op_done_o && op_ready_o)
		else $error("done not a single pulse before idle");
	start_taken_a: assert property (op_start_i && op_ready_o |=> !op_ready_o)
		else $error("start not taken");
	mask_bit0_a: assert property (op_status_o[0] == 1'b0)
		else $error("reserved status bit reported");
	pin_wait_a: assert property (!ready_busy_i |-> !op_done_o)
		else $error("done while device busy");
	done_ready_a: assert property (op_done_o |-> op_status_o[7])
		else $error("done without ready status");
endmodule

bind fes_erase_host fes_erase_host_checker u_chk (
	.ref_clk_i(ref_clk_i), .srst_i(srst_i), .op_start_i(op_start_i),
	.op_ready_o(op_ready_o), .op_done_o(op_done_o), .op_status_o(op_status_o),
	.ready_busy_i(ready_busy_i), .flash_ce_n_o(flash_ce_n_o),
	.flash_we_n_o(flash_we_n_o), .flash_oe_n_o(flash_oe_n_o),
	.flash_dq_oe_o(flash_dq_oe_o)
);

// >>> testbench/fes_flash_model.sv
`timescale 1ns/1ps
module fes_flash_model (
	input  wire logic        ce_n_i,
	input  wire logic        we_n_i,
	input  wire logic        oe_n_i,
	input  wire logic [19:0] addr_i,
	input  wire logic [7:0]  dq_i,
	input  wire logic [7:0]  fault_i,
	input  wire logic [15:0] busy_ns_i,
	output logic [7:0]       dq_o,
	output logic             ready_busy_o,
	output logic [7:0]       setup_o,
	output logic [7:0]       clr_cnt_o,
	output logic [19:0]      cfm_addr_o,
	output logic             arr_mode_o
);
	logic [5:1] err;
	logic       rdy = 1'b1;
	event       go_ev;
	wire logic  wr_act = !ce_n_i && !we_n_i;
	initial {err, setup_o, clr_cnt_o, cfm_addr_o, arr_mode_o} = '0;
	// ==============================
	// Command decode
	// Latch when the write ends; select and strobe may rise in the same step
	always @(negedge wr_act) begin
		arr_mode_o = (dq_i == 8'hFF);
		if (dq_i == 8'h50) begin
			err = '0;
			clr_cnt_o++;
		end
		if (dq_i == 8'h20 || dq_i == 8'h30)
			setup_o = dq_i;
		if (dq_i == 8'hD0) begin
			cfm_addr_o = addr_i;
			->go_ev;
		end
	end
	// ==============================
	// Erase run
	always begin
		@(go_ev);
		rdy = 1'b0;
		// Finish off the clock edge so the host never samples a changing pin
		#(busy_ns_i + 10);
		// flags only sampled at operation end; protect stands for locked blocks
		err = err | fault_i[5:1];
		rdy = 1'b1;
	end
	assign ready_busy_o = rdy;
	// suspend bit 6 stays 0; lock configuration never shows in status
	// Reserved bit reads 1 so a host that forgets to mask it is seen
	assign dq_o = (!ce_n_i && !oe_n_i) ? {rdy, 1'b0, err, 1'b1} : ~{rdy, 1'b0, err, 1'b1};
endmodule

// >>> testbench/fes_erase_host_tb_top.sv
`timescale 1ns/1ps
module fes_erase_host_tb_top;
	import fes_pkg::*;
	logic        ref_clk_i = 1'b0, srst_i = 1'b1, op_start_i = 1'b0, op_chip_i = 1'b0;
	logic        op_check_i = 1'b0, op_last_i = 1'b0, arr_mode;
	logic [19:0] op_addr_i = '0, flash_addr_o, cfm_addr;
	logic        op_ready_o, op_done_o, op_suspended_o, ready_busy_i;
	fes_result_t op_result_o;
	logic [7:0]  op_status_o, flash_dq_o, flash_dq_i, setup, clr_cnt, fault = 8'h00;
	logic        flash_ce_n_o, flash_we_n_o, flash_oe_n_o, flash_dq_oe_o;
	logic [15:0] busy_ns = 16'h012C;
	int          n_errors = 0, check_count = 0, cyc = 0;

	fes_erase_host #(.AW(20)) dut (
		.ref_clk_i(ref_clk_i), .srst_i(srst_i), .op_start_i(op_start_i),
		.op_chip_i(op_chip_i), .op_addr_i(op_addr_i), .op_check_i(op_check_i),
		.op_last_i(op_last_i), .op_ready_o(op_ready_o), .op_done_o(op_done_o),
		.op_result_o(op_result_o), .op_status_o(op_status_o),
		.op_suspended_o(op_suspended_o), .ready_busy_i(ready_busy_i),
		.flash_addr_o(flash_addr_o), .flash_ce_n_o(flash_ce_n_o),
		.flash_we_n_o(flash_we_n_o), .flash_oe_n_o(flash_oe_n_o),
		.flash_dq_o(flash_dq_o), .flash_dq_oe_o(flash_dq_oe_o), .flash_dq_i(flash_dq_i));
	fes_flash_model u_flash (
		.ce_n_i(flash_ce_n_o), .we_n_i(flash_we_n_o), .oe_n_i(flash_oe_n_o),
		.addr_i(flash_addr_o), .dq_i(flash_dq_o), .fault_i(fault), .busy_ns_i(busy_ns),
		.dq_o(flash_dq_i), .ready_busy_o(ready_busy_i), .setup_o(setup),
		.clr_cnt_o(clr_cnt), .cfm_addr_o(cfm_addr), .arr_mode_o(arr_mode));

	// ==============================
	// Clock, timeout and shared tasks
	initial forever #50 ref_clk_i = ~ref_clk_i;
	always @(posedge ref_clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			$display("[FAIL] %0t timeout", $time);
			report_and_stop();
		end
	end
	task automatic report_and_stop();
		$display("errors %0d checks %0d", n_errors, check_count);
		if (n_errors == 0 && check_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [19:0] got, input logic [19:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic run_op(input logic chip, input logic [19:0] addr, input logic ck,
		input logic last, input logic [7:0] flt);
		do @(negedge ref_clk_i); while (op_ready_o !== 1'b1);
		@(posedge ref_clk_i);
		fault <= flt;
		{op_start_i, op_chip_i, op_addr_i, op_check_i, op_last_i} <= {1'b1, chip, addr, ck, last};
		@(posedge ref_clk_i);
		op_start_i <= 1'b0;
		do @(negedge ref_clk_i); while (op_done_o !== 1'b1);
	endtask

	// ==============================
	// Scenarios
	task automatic t_block();
		run_op(1'b0, 20'h4A5C3, 1'b1, 1'b0, 8'h00);
		chk(op_result_o, RES_OK, "block result");
		chk(setup, 8'h20, "block setup");
		chk(cfm_addr, 20'h4A5C3, "block confirm address");
		busy_ns = 16'h0BB8;
		run_op(1'b0, 20'h0001F, 1'b1, 1'b0, 8'h00);
		chk(cfm_addr, 20'h0001F, "second confirm address");
		$display("test block done");
	endtask
	task automatic t_chip_faults();
		logic [7:0] flt[6] = '{8'h08, 8'h02, 8'h30, 8'h20, 8'h0A, 8'h32};
		logic [2:0] exp[6] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h1, 3'h2};
		logic [7:0] c0;
		for (int i = 0; i < 6; i++) begin
			c0 = clr_cnt;
			run_op(1'b1, 20'h00000, 1'b0, 1'b0, flt[i]);
			chk(op_result_o, exp[i], "chip result");
			chk(setup, 8'h30, "chip setup");
			chk(op_status_o, 8'h80 | flt[i], "chip status");
			chk(clr_cnt, c0 + 8'h01, "clear after error");
		end
		$display("test chip faults done");
	endtask
	task automatic t_sticky();
		logic [7:0] c0;
		c0 = clr_cnt;
		run_op(1'b0, 20'h10000, 1'b0, 1'b0, 8'h02);
		chk(op_result_o, RES_OK, "deferred check");
		run_op(1'b0, 20'h20000, 1'b1, 1'b0, 8'h00);
		chk(op_result_o, RES_PROTECT, "sticky error");
		chk(op_suspended_o, 1'b0, "suspend flag");
		chk(clr_cnt, c0 + 8'h01, "single clear");
		$display("test sticky done");
	endtask
	task automatic t_last();
		run_op(1'b0, 20'h30000, 1'b1, 1'b1, 8'h00);
		chk(op_result_o, RES_OK, "last result");
		chk(arr_mode, 1'b1, "array read mode");
		$display("test last done");
	endtask

	initial begin
		repeat (16) @(posedge ref_clk_i);
		srst_i <= 1'b0;
		t_block();
		t_chip_faults();
		t_sticky();
		t_last();
		report_and_stop();
	end
endmodule
